// ==== include/cjm_pkg.sv ====
// Package for the jump / copy / idle / complement execution slice.
// Assumes a 16-bit core that presents decoded instruction words with a valid strobe.
package cjm_pkg;
  localparam int WORD_W = 16;
  localparam int OFFS_W = 10;
  // Jump word: top three bits 001, condition in [12:10], offset in [9:0]
  localparam logic [2:0] JUMP_PREFIX = 3'h1;
  localparam int JUMP_PFX_HI = 15;
  localparam int JUMP_PFX_LO = 13;
  localparam int COND_HI = 12;
  localparam int COND_LO = 10;
  // Condition codes of the jump group
  localparam logic [2:0] COND_NOCARRY = 3'h0;
  localparam logic [2:0] COND_NONZERO = 3'h1;
  localparam logic [2:0] COND_ZERO = 3'h2;
  localparam logic [2:0] COND_CARRY = 3'h3;
  localparam logic [2:0] COND_NEG = 3'h4;
  localparam logic [2:0] COND_SGE = 3'h5;
  localparam logic [2:0] COND_SLT = 3'h6;
  localparam logic [2:0] COND_ALWAYS = 3'h7;
  // Flag positions inside the flags word
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_GLOBAL_IRQ_ENABLE = 3;
  localparam int FLG_CORE_HALT = 4;
  localparam int FLG_OSC = 5;
  localparam int FLG_V = 8;
  localparam logic [WORD_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] FLAGS_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_STEP = 16'h0002;
  localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [3:0] CONST_GEN_REG = 4'h3;
  // Top bit of the low byte, used by byte-wide flag tests
  localparam int BYTE_MSB = 7;
  // Operation selector presented alongside non-jump words
  typedef enum logic [1:0] {CJM_OP_OTHER, CJM_OP_COPY, CJM_OP_IDLE, CJM_OP_COMPL} cjm_op_e;
  // Request: instruction and its operands
  typedef struct packed {
    logic [WORD_W-1:0] instr;
    cjm_op_e op;
    logic [WORD_W-1:0] srcVal;
    logic [WORD_W-1:0] dstVal;
    logic [3:0] dstReg;
    logic byteMode;
  } cjm_req_s;
  // Result: write-back of destination
  typedef struct packed {
    logic wrEn;
    logic [3:0] wrReg;
    logic [WORD_W-1:0] wrData;
  } cjm_wb_s;
endpackage : cjm_pkg

// ==== verilog/cjm_exec.sv ====
// Execution slice for the relative jumps, copy, idle and complement flag update.
// Assumes the core fetch stage already advanced the pointer past the word presented.
`timescale 1ns/1ps
`default_nettype none
module cjm_exec (
  input wire logic clk, // Core clock, 50 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic reqValid, // One-cycle strobe: req holds a word
  input wire cjm_pkg::cjm_req_s req, // Instruction and operands
  input wire logic [cjm_pkg::WORD_W-1:0] nextPtr, // Pointer of the following word
  output logic [cjm_pkg::WORD_W-1:0] instrPointer, // Next fetch address
  output logic [cjm_pkg::WORD_W-1:0] flagsWord, // Status and mode bits
  output var cjm_pkg::cjm_wb_s wb, // Destination write-back
  output logic branchTaken // Pulse: jump taken
);
  import cjm_pkg::*;

  // Decode helpers shared by several processes
  function automatic logic isJump(input logic [WORD_W-1:0] w);
    return w[JUMP_PFX_HI:JUMP_PFX_LO] == JUMP_PREFIX;
  endfunction : isJump

  function automatic logic condMet(input logic [2:0] cc, input logic [WORD_W-1:0] f);
    logic r;
    r = 1'b0;
    case (cc)
      COND_CARRY: r = f[FLG_C];
      COND_NOCARRY: r = ~f[FLG_C];
      COND_ZERO: r = f[FLG_Z];
      COND_NONZERO: r = ~f[FLG_Z];
      COND_NEG: r = f[FLG_N];
      COND_SGE: r = ~(f[FLG_N] ^ f[FLG_V]);
      COND_SLT: r = f[FLG_N] ^ f[FLG_V];
      COND_ALWAYS: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : condMet

  logic jumpNow;
  logic takeNow;
  logic [WORD_W-1:0] targetD;
  logic [WORD_W-1:0] complRes;
  logic complNonZero;
  logic complNeg;

  // Jump decode and target; a wrapping 16-bit add gives the signed reach for free
  always_comb begin
    jumpNow = reqValid && isJump(req.instr);
    takeNow = jumpNow && condMet(req.instr[COND_HI:COND_LO], flagsWord);
    targetD = nextPtr + {{(WORD_W-OFFS_W-1){req.instr[OFFS_W-1]}}, req.instr[OFFS_W-1:0], 1'b0};
  end

  // Complement result, honouring byte width for the flag tests
  // Byte mode judges only the low byte; the upper byte still inverts in the write-back
  always_comb begin
    complRes = ~req.dstVal;
    if (req.byteMode) begin
      complNonZero = |complRes[BYTE_MSB:0];
      complNeg = req.dstVal[BYTE_MSB];
    end else begin
      complNonZero = |complRes;
      complNeg = req.dstVal[WORD_W-1];
    end
  end

  // Fetch pointer: jump target if taken, else fall through
  // Non-jump words step too, so the pointer always names the next fetch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instrPointer <= PTR_RESET;
    end else if (reqValid) begin
      instrPointer <= takeNow ? targetD : nextPtr;
    end
  end

  // Taken pulse for the fetch stage to flush
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      branchTaken <= 1'b0;
    end else begin
      branchTaken <= takeNow;
    end
  end

  // Flags: only the complement touches them; mode bits are never written here
  // jumps leave flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flagsWord <= FLAGS_RESET;
    end else if (reqValid && !isJump(req.instr) && req.op == CJM_OP_COMPL) begin
      flagsWord[FLG_C] <= complNonZero;
      flagsWord[FLG_Z] <= ~complNonZero;
      flagsWord[FLG_N] <= req.byteMode ? complRes[BYTE_MSB] : complRes[WORD_W-1];
      flagsWord[FLG_V] <= complNeg;
    end
  end

  // Destination write-back; jumps write nothing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb <= '0;
    end else begin
      wb <= '0;
      if (reqValid && !isJump(req.instr)) begin
        case (req.op)
          CJM_OP_COPY: begin
            wb.wrEn <= 1'b1;
            wb.wrReg <= req.dstReg;
            wb.wrData <= req.srcVal;
          end
          CJM_OP_IDLE: begin
            wb.wrEn <= 1'b1;
            wb.wrReg <= CONST_GEN_REG;
            wb.wrData <= ZERO_WORD;
          end
          CJM_OP_COMPL: begin
            wb.wrEn <= 1'b1;
            wb.wrReg <= req.dstReg;
            wb.wrData <= complRes;
          end
          default: wb <= '0;
        endcase
      end
    end
  end

  // Checks
  // Flag expectations come from the operand, so they do not lean on the write-back

  // chk_jump_target_value
  chk_jump_target_value: assert property (@(posedge clk) disable iff (!rst_n)
    takeNow |=> instrPointer == $past(targetD))
    else $error("taken jump target wrong");

  // chk_fall_through
  chk_fall_through: assert property (@(posedge clk) disable iff (!rst_n)
    (jumpNow && !takeNow) |=> instrPointer == $past(nextPtr) && !branchTaken)
    else $error("untaken jump did not fall through");

  // chk_carry_jump
  chk_carry_jump: assert property (@(posedge clk) disable iff (!rst_n)
    (jumpNow && req.instr[COND_HI:COND_LO] == COND_CARRY) |=> branchTaken == $past(flagsWord[FLG_C]))
    else $error("carry jump decision wrong");

  // chk_nocarry_jump
  chk_nocarry_jump: assert property (@(posedge clk) disable iff (!rst_n)
    (jumpNow && req.instr[COND_HI:COND_LO] == COND_NOCARRY) |=> branchTaken != $past(flagsWord[FLG_C]))
    else $error("no-carry jump decision wrong");

  // chk_zero_jump
  chk_zero_jump: assert property (@(posedge clk) disable iff (!rst_n)
    (jumpNow && req.instr[COND_HI:COND_LO] == COND_ZERO) |=> branchTaken == $past(flagsWord[FLG_Z]))
    else $error("zero jump decision wrong");

  // chk_nonzero_jump
  chk_nonzero_jump: assert property (@(posedge clk) disable iff (!rst_n)
    (jumpNow && req.instr[COND_HI:COND_LO] == COND_NONZERO) |=> branchTaken != $past(flagsWord[FLG_Z]))
    else $error("nonzero jump decision wrong");

  // chk_neg_jump
  chk_neg_jump: assert property (@(posedge clk) disable iff (!rst_n)
    (jumpNow && req.instr[COND_HI:COND_LO] == COND_NEG) |=> branchTaken == $past(flagsWord[FLG_N]))
    else $error("negative jump decision wrong");

  // chk_sge_jump
  chk_sge_jump: assert property (@(posedge clk) disable iff (!rst_n)
    (jumpNow && req.instr[COND_HI:COND_LO] == COND_SGE)
      |=> branchTaken == !($past(flagsWord[FLG_N]) ^ $past(flagsWord[FLG_V])))
    else $error("signed ge decision wrong");

  // chk_slt_jump
  chk_slt_jump: assert property (@(posedge clk) disable iff (!rst_n)
    (jumpNow && req.instr[COND_HI:COND_LO] == COND_SLT)
      |=> branchTaken == ($past(flagsWord[FLG_N]) ^ $past(flagsWord[FLG_V])))
    else $error("signed lt decision wrong");

  // chk_always_jump
  chk_always_jump: assert property (@(posedge clk) disable iff (!rst_n)
    (jumpNow && req.instr[COND_HI:COND_LO] == COND_ALWAYS) |=> branchTaken)
    else $error("unconditional jump not taken");

  // chk_jump_reach
  chk_jump_reach: assert property (@(posedge clk) disable iff (!rst_n)
    takeNow |=> ($signed(instrPointer - $past(nextPtr) + WORD_STEP) >= -16'sd1022)
      && ($signed(instrPointer - $past(nextPtr) + WORD_STEP) <= 16'sd1024))
    else $error("jump outside reach");

  // chk_jump_keeps_flags
  chk_jump_keeps_flags: assert property (@(posedge clk) disable iff (!rst_n)
    jumpNow |=> $stable(flagsWord) && !wb.wrEn)
    else $error("jump changed flags or wrote back");

  // chk_copy_writes
  chk_copy_writes: assert property (@(posedge clk) disable iff (!rst_n)
    (reqValid && !isJump(req.instr) && req.op == CJM_OP_COPY)
      |=> wb.wrEn && wb.wrData == $past(req.srcVal) && $stable(flagsWord))
    else $error("copy write-back wrong");

  // chk_idle_writes
  chk_idle_writes: assert property (@(posedge clk) disable iff (!rst_n)
    (reqValid && !isJump(req.instr) && req.op == CJM_OP_IDLE)
      |=> wb.wrEn && wb.wrReg == CONST_GEN_REG && wb.wrData == ZERO_WORD && $stable(flagsWord))
    else $error("idle op wrong");

  // chk_compl_flags
  chk_compl_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (reqValid && !isJump(req.instr) && req.op == CJM_OP_COMPL && !req.byteMode)
      |=> flagsWord[FLG_C] == ($past(req.dstVal) != 16'hFFFF) && flagsWord[FLG_V] == $past(req.dstVal[WORD_W-1])
        && flagsWord[FLG_OSC:FLG_GLOBAL_IRQ_ENABLE] == $past(flagsWord[FLG_OSC:FLG_GLOBAL_IRQ_ENABLE]))
    else $error("complement flags wrong");

  chk_compl_byte: assert property (@(posedge clk) disable iff (!rst_n)
    (reqValid && !isJump(req.instr) && req.op == CJM_OP_COMPL && req.byteMode)
      |=> flagsWord[FLG_C] == ($past(req.dstVal[BYTE_MSB:0]) != 8'hFF)
        && flagsWord[FLG_Z] == ($past(req.dstVal[BYTE_MSB:0]) == 8'hFF)
        && flagsWord[FLG_N] == !$past(req.dstVal[BYTE_MSB])
        && flagsWord[FLG_V] == $past(req.dstVal[BYTE_MSB]))
    else $error("byte complement flags wrong");

  chk_compl_data: assert property (@(posedge clk) disable iff (!rst_n)
    (reqValid && !isJump(req.instr) && req.op == CJM_OP_COMPL)
      |=> wb.wrEn && wb.wrReg == $past(req.dstReg) && wb.wrData == ~$past(req.dstVal))
    else $error("complement write-back wrong");

  chk_compl_word_zn: assert property (@(posedge clk) disable iff (!rst_n)
    (reqValid && !isJump(req.instr) && req.op == CJM_OP_COMPL && !req.byteMode)
      |=> flagsWord[FLG_Z] == ($past(req.dstVal) == 16'hFFFF) && flagsWord[FLG_N] == !$past(req.dstVal[WORD_W-1]))
    else $error("complement zero or negative flag wrong");

  chk_copy_reg: assert property (@(posedge clk) disable iff (!rst_n)
    (reqValid && !isJump(req.instr) && req.op == CJM_OP_COPY) |=> wb.wrReg == $past(req.dstReg))
    else $error("copy destination register wrong");

  // other words step to next pointer
  chk_seq_advance: assert property (@(posedge clk) disable iff (!rst_n)
    (reqValid && !isJump(req.instr)) |=> instrPointer == $past(nextPtr) && !branchTaken)
    else $error("non-jump word did not advance pointer");

  chk_ptr_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !reqValid |=> $stable(instrPointer) && !branchTaken && !wb.wrEn)
    else $error("outputs moved without a word");

  chk_flags_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(reqValid && !isJump(req.instr) && req.op == CJM_OP_COMPL) |=> $stable(flagsWord))
    else $error("flags changed without a complement");

  chk_taken_origin: assert property (@(posedge clk) disable iff (!rst_n)
    branchTaken |-> $past(jumpNow))
    else $error("taken pulse without a jump");

  chk_wb_origin: assert property (@(posedge clk) disable iff (!rst_n)
    wb.wrEn |-> $past(reqValid) && !$past(jumpNow))
    else $error("write-back without a non-jump word");

  // Cover points for the main scenarios
  cov_jump_taken: cover property (@(posedge clk) disable iff (!rst_n) takeNow);
  cov_jump_not_taken: cover property (@(posedge clk) disable iff (!rst_n) jumpNow && !takeNow);
  cov_backward_jump: cover property (@(posedge clk) disable iff (!rst_n) takeNow && req.instr[OFFS_W-1]);
  cov_compl: cover property (@(posedge clk) disable iff (!rst_n)
    reqValid && !isJump(req.instr) && req.op == CJM_OP_COMPL);
  cov_byte_compl: cover property (@(posedge clk) disable iff (!rst_n)
    reqValid && !isJump(req.instr) && req.op == CJM_OP_COMPL && req.byteMode);
endmodule : cjm_exec
`default_nettype wire

// ==== dv/cjm_exec_bench.sv ====
// Self-checking bench for the jump / copy / idle / complement slice.
// Assumes the slice answers every presented word one cycle later.
`timescale 1ns/1ps
`default_nettype none
module cjm_exec_bench;
  import cjm_pkg::*;
  typedef struct packed {
    logic [WORD_W-1:0] ip;
    logic [WORD_W-1:0] fl;
    cjm_wb_s wb;
    logic br;
  } cjm_exp_s;
  logic clk, rst_n, reqValid, branchTaken;
  logic vPrev = 1'b0;
  logic byteSel = 1'b0;
  cjm_req_s req;
  cjm_wb_s wb;
  logic [WORD_W-1:0] nextPtr, instrPointer, flagsWord, flagsModel;
  cjm_exp_s expQ[$];
  cjm_exp_s got;
  integer seed, badCount, nTests;

  cjm_exec uut (
    .clk(clk), .rst_n(rst_n), .reqValid(reqValid), .req(req), .nextPtr(nextPtr),
    .instrPointer(instrPointer), .flagsWord(flagsWord), .wb(wb), .branchTaken(branchTaken)
  );

  // Core clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // One comparison; an unknown never passes for a match
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    nTests = nTests + 1;
    if (seen !== expv) begin
      badCount = badCount + 1;
      $display("[ERR] %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  task automatic finishTest();
    if (badCount == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finishTest

  // Notes the expected answer, then presents the word at the next edge
  task automatic issue(input logic [15:0] ins, input cjm_op_e op, input logic [15:0] src, input logic [15:0] dst,
                       input logic [3:0] rg);
    cjm_exp_s e;
    logic tk;
    logic [15:0] np;
    logic [15:0] res;
    np = 16'($random(seed));
    np[0] = 1'b0; // Word aligned fetch pointer
    res = ~dst;
    e = '0;
    e.ip = np;
    e.fl = flagsModel;
    if (ins[15:13] == JUMP_PREFIX) begin
      case (ins[12:10])
        COND_NOCARRY: tk = ~flagsModel[FLG_C];
        COND_NONZERO: tk = ~flagsModel[FLG_Z];
        COND_ZERO: tk = flagsModel[FLG_Z];
        COND_CARRY: tk = flagsModel[FLG_C];
        COND_NEG: tk = flagsModel[FLG_N];
        COND_SGE: tk = ~(flagsModel[FLG_N] ^ flagsModel[FLG_V]);
        COND_SLT: tk = flagsModel[FLG_N] ^ flagsModel[FLG_V];
        default: tk = 1'b1;
      endcase
      e.br = tk;
      if (tk) e.ip = np + {{5{ins[9]}}, ins[9:0], 1'b0};
    end else if (op == CJM_OP_COPY) begin
      e.wb = {1'b1, rg, src};
    end else if (op == CJM_OP_IDLE) begin
      e.wb = {1'b1, CONST_GEN_REG, ZERO_WORD};
    end else if (op == CJM_OP_COMPL) begin
      e.wb = {1'b1, rg, res};
      e.fl[FLG_C] = byteSel ? |res[7:0] : |res;
      e.fl[FLG_Z] = ~e.fl[FLG_C];
      e.fl[FLG_N] = byteSel ? res[7] : res[15];
      e.fl[FLG_V] = byteSel ? dst[7] : dst[15];
    end
    flagsModel = e.fl;
    expQ.push_back(e);
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{ins, op, src, dst, rg, byteSel};
    nextPtr <= np;
  endtask : issue

  // Oldest note is judged one edge after its word was taken
  always @(posedge clk) begin
    if (vPrev) begin
      if (expQ.size() == 0) begin
        check("queue", 32'h1, 32'h0);
      end else begin
        got = expQ.pop_front();
        check("instrPointer", 32'(instrPointer), 32'(got.ip));
        check("branchTaken", 32'(branchTaken), 32'(got.br));
        check("flagsWord", 32'(flagsWord), 32'(got.fl));
        if (got.wb.wrEn) check("wb", 32'(wb), 32'(got.wb));
        else check("wrEn", 32'(wb.wrEn), 32'h0);
      end
    end
    vPrev <= reqValid;
  end

  // Hang guard: running out counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    check("timeout", 32'h1, 32'h0);
    finishTest();
  end

  // Main sequence
  initial begin
    logic [31:0] r;
    seed = 32'h0A9E;
    badCount = 0;
    nTests = 0;
    rst_n = 1'b0;
    reqValid = 1'b0;
    req = '0;
    nextPtr = '0;
    flagsModel = FLAGS_RESET;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    issue({JUMP_PREFIX, COND_ALWAYS, 10'h1FF}, CJM_OP_OTHER, '0, '0, '0);
    issue({JUMP_PREFIX, COND_ALWAYS, 10'h200}, CJM_OP_OTHER, '0, '0, '0);
    // Every condition code under four flag states, back to back
    for (int s = 0; s < 4; s++) begin
      if (s > 0) issue(16'h4000, CJM_OP_COMPL, '0, (s == 1) ? 16'hFFFF : (s == 2) ? 16'h0000 : 16'h8000, 4'h5);
      for (int c = 0; c < 8; c++) begin
        issue({JUMP_PREFIX, 3'(c), 10'($random(seed))}, CJM_OP_OTHER, '0, '0, '0);
      end
    end
    // Byte complement judges only the low byte
    byteSel = 1'b1;
    issue(16'h4000, CJM_OP_COMPL, '0, 16'h12FF, 4'h6);
    issue(16'h4000, CJM_OP_COMPL, '0, 16'hFF7F, 4'h6);
    // Random mix of jumps, copies, idles, complements and other words, with gaps
    for (int i = 0; i < 200; i++) begin
      r = $random(seed);
      byteSel = r[21];
      if (r[0]) issue({JUMP_PREFIX, r[12:0]}, CJM_OP_OTHER, '0, '0, '0);
      else issue({3'h2, r[12:0]}, cjm_op_e'(r[14:13]), 16'($random(seed)), 16'($random(seed)), r[20:17]);
      if (r[31]) begin
        @(posedge clk);
        reqValid <= 1'b0;
      end
    end
    @(posedge clk);
    reqValid <= 1'b0;
    repeat (4) @(posedge clk);
    if (expQ.size() != 0) check("drain", 32'(expQ.size()), 32'h0);
    // Mid-run reset: every output returns to its reset value
    rst_n <= 1'b0;
    byteSel = 1'b0;
    repeat (2) @(posedge clk);
    check("rstPointer", 32'(instrPointer), 32'(PTR_RESET));
    check("rstFlags", 32'(flagsWord), 32'(FLAGS_RESET));
    check("rstWb", 32'(wb), 32'h0);
    check("rstTaken", 32'(branchTaken), 32'h0);
    rst_n <= 1'b1;
    flagsModel = FLAGS_RESET;
    // Cleared flags: carry jump falls through, nonzero jump goes backwards
    issue({JUMP_PREFIX, COND_CARRY, 10'h010}, CJM_OP_OTHER, '0, '0, '0);
    issue({JUMP_PREFIX, COND_NONZERO, 10'h3F0}, CJM_OP_OTHER, '0, '0, '0);
    @(posedge clk);
    reqValid <= 1'b0;
    repeat (4) @(posedge clk);
    if (expQ.size() != 0) check("drain", 32'(expQ.size()), 32'h0);
    finishTest();
  end
endmodule : cjm_exec_bench
`default_nettype wire
